//--- shared/worpc_defines.svh
`ifndef WORPC_DEFINES_SVH
`define WORPC_DEFINES_SVH

// ==========================================================
// register byte offsets
`define WORPC_OFF_CTRL 8'h00
`define WORPC_OFF_SLEEP 8'h04
`define WORPC_OFF_WINDOW 8'h08
`define WORPC_OFF_CALINT 8'h0C
`define WORPC_OFF_DWELL 8'h10
`define WORPC_OFF_STAMP 8'h14
`define WORPC_OFF_STATE 8'h18
`define WORPC_OFF_IRQ_STAT 8'h1C
`define WORPC_OFF_IRQ_CLR 8'h20
`define WORPC_OFF_IRQ_EN 8'h24

// ==========================================================
// control register fields
`define WORPC_CTRL_W 6
`define WORPC_CTRL_POLL 0
`define WORPC_CTRL_DIV 1
`define WORPC_CTRL_DIFF 2
`define WORPC_CTRL_PRE 3
`define WORPC_CTRL_EXTREF 4
`define WORPC_CTRL_AUTOCAL 5

// ==========================================================
// interrupt event bits
`define WORPC_IRQ_W 3
`define WORPC_IRQ_PKT 0
`define WORPC_IRQ_TMO 1
`define WORPC_IRQ_CAL 2

// ==========================================================
// reset values
`define WORPC_RST_CTRL 6'h00
`define WORPC_RST_SLEEP 16'h0010
`define WORPC_RST_WINDOW 16'h0100
`define WORPC_RST_CALINT 16'h0008
`define WORPC_RST_DWELL 16'h0040
`define WORPC_RST_TRIM 8'h80

// ==========================================================
// clock rates, nominal reference cycles per rc period
`define WORPC_REF_HZ 250000000
`define WORPC_RC_HZ 40000
`define WORPC_CAL_NOMINAL (`WORPC_REF_HZ / `WORPC_RC_HZ)

`endif

//--- shared/worpc_pkg.sv
package worpc_pkg;

    // ======================================================
    // polling sequencer states
    typedef enum logic [2:0] {
        WORPC_IDLE,
        WORPC_SLEEP,
        WORPC_CAL,
        WORPC_LISTEN,
        WORPC_PACKET,
        WORPC_ACK
    } worpc_state_t;

    // ======================================================
    // status from the receive and transmit chains
    typedef struct packed {
        logic rssi_above;
        logic preamble_det;
        logic pkt_done;
        logic ack_req;
        logic ack_done;
    } worpc_radio_in_t;

endpackage

//--- src/worpc_countdown.sv
`include "worpc_defines.svh"

module worpc_countdown #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control
    input wire logic start,
    input wire logic [W-1:0] load,
    input wire logic en,
    // state
    output logic done,
    output logic busy,
    output logic [W-1:0] count
);
    import worpc_pkg::*;

    logic [W-1:0] next_count;

    // ======================================================
    // zero load counts as one so a start always ends
    assign next_count = start ? ((load == '0) ? W'(1) : load) :
        (en && count != '0) ? count - W'(1) : count;
    // done looks at en and the count, not at start, so a caller may restart from it
    assign done = en && (count == W'(1));
    assign busy = (count != '0);

    // counter register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule

//--- src/worpc_antsel.sv
`include "worpc_defines.svh"

module worpc_antsel #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control
    input wire logic search,
    input wire logic diff_mode,
    input wire logic [W-1:0] dwell,
    // switch pins
    output logic ant_sel,
    output logic ant_sel_n
);
    import worpc_pkg::*;

    logic dwell_done;
    logic [W-1:0] dwell_cnt;
    logic next_ant;

    // ======================================================
    // dwell timer restarts on each toggle; the restart is taken
    // from search and the count; done itself does not depend on it
    worpc_countdown #(.W(W)) u_dwell (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(search && (dwell_cnt == W'(1) || dwell_cnt == '0)),
        .load(dwell),
        .en(search),
        .done(dwell_done),
        .busy(),
        .count(dwell_cnt)
    );

    // level only moves while searching, so ack keeps it
    assign next_ant = (search && dwell_done) ? !ant_sel : ant_sel;

    // switch outputs, complement only in differential mode
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ant_sel <= 1'b0;
            ant_sel_n <= 1'b0;
        end else begin
            ant_sel <= next_ant;
            ant_sel_n <= diff_mode & !next_ant;
        end
    end

    // ======================================================
    // checks
    property p_toggle;
        @(posedge ref_clk) disable iff (!resetn)
        search && dwell_done |=> ant_sel != $past(ant_sel);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("antenna did not toggle after dwell");

    property p_dwell_hold;
        @(posedge ref_clk) disable iff (!resetn)
        !(search && dwell_done) |=> $stable(ant_sel);
    endproperty
    a_dwell_hold: assert property (p_dwell_hold)
        else $error("antenna moved before dwell ended");

    property p_diff;
        @(posedge ref_clk) disable iff (!resetn)
        ##1 ant_sel_n == ($past(diff_mode) & !ant_sel);
    endproperty
    a_diff: assert property (p_diff)
        else $error("differential output wrong");
endmodule

//--- src/worpc_poll_ctrl.sv
// ==========================================================
// Function
// - the sleep timer wakes the receiver by itself, no host action.
// - a wake-up window with no valid signal ends back in sleep.
// - sleep interval and receive window length are programmable.
// - each incoming message is stamped with the sleep timer value.
// - the sleep timer advances only on the rc oscillator clock.
// - with autocal on, the rc clock is recalibrated every N wake-ups.
// - the external reference is on when needed, off while sleeping.
// - the block cycles sleep and receive, sleep set below preamble.
// - diversity toggles the antenna select until a valid signal.
// - antenna select drives a complementary pair as well as one pin.
// - an acknowledge is sent with the antenna select held.
// - validity comes from rssi threshold or preamble detect, by config.
// - calibration trims the rc clock to 40 kHz against the reference.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`include "worpc_defines.svh"

module worpc_poll_ctrl #(
    parameter int TW = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // rc oscillator
    input wire logic rc_clk_in,
    output logic [7:0] rc_trim,
    // radio chains
    input wire worpc_pkg::worpc_radio_in_t radio,
    output logic rx_on,
    output logic ack_tx_on,
    output logic ext_ref_en,
    // antenna switch
    output logic ant_sel,
    output logic ant_sel_n,
    // interrupt
    output logic irq
);
    import worpc_pkg::*;

    localparam logic [15:0] CAL_NOM = 16'(`WORPC_CAL_NOMINAL);

    worpc_state_t state, next_state;
    logic [`WORPC_CTRL_W-1:0] ctrl;
    logic [TW-1:0] sleep_ticks, rx_window, cal_interval, dwell;
    logic [TW-1:0] wake_time, timestamp;
    logic [`WORPC_IRQ_W-1:0] irq_stat, irq_en, irq_ev;
    logic [15:0] cal_cnt;
    logic cal_arm, cal_due, rc_q, rc_tick;
    logic sleep_done, win_done, calint_done, calint_busy;
    logic [TW-1:0] sleep_cnt, win_cnt;
    logic sig_valid, enter_sleep, enter_listen, cal_fin;
    logic [31:0] rd_mux;
    logic sel_ctrl, sel_sleep, sel_win, sel_calint, sel_dwell;
    logic sel_stamp, sel_state, sel_istat, sel_iclr, sel_ien;

    // ======================================================
    // address decode
    assign sel_ctrl = (addr == `WORPC_OFF_CTRL);
    assign sel_sleep = (addr == `WORPC_OFF_SLEEP);
    assign sel_win = (addr == `WORPC_OFF_WINDOW);
    assign sel_calint = (addr == `WORPC_OFF_CALINT);
    assign sel_dwell = (addr == `WORPC_OFF_DWELL);
    assign sel_stamp = (addr == `WORPC_OFF_STAMP);
    assign sel_state = (addr == `WORPC_OFF_STATE);
    assign sel_istat = (addr == `WORPC_OFF_IRQ_STAT);
    assign sel_iclr = (addr == `WORPC_OFF_IRQ_CLR);
    assign sel_ien = (addr == `WORPC_OFF_IRQ_EN);

    // read select; unmapped and write-only offsets read zero
    assign rd_mux =
        sel_ctrl ? 32'(ctrl) :
        sel_sleep ? 32'(sleep_ticks) :
        sel_win ? 32'(rx_window) :
        sel_calint ? 32'(cal_interval) :
        sel_dwell ? 32'(dwell) :
        sel_stamp ? 32'(timestamp) :
        sel_state ? {16'h0000, rc_trim, 3'h0, ant_sel, 1'b0, 3'(state)} :
        sel_istat ? 32'(irq_stat) :
        sel_ien ? 32'(irq_en) : 32'h00000000;

    // configuration registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= `WORPC_RST_CTRL;
            sleep_ticks <= TW'(`WORPC_RST_SLEEP);
            rx_window <= TW'(`WORPC_RST_WINDOW);
            cal_interval <= TW'(`WORPC_RST_CALINT);
            dwell <= TW'(`WORPC_RST_DWELL);
            irq_en <= '0;
        end else if (wr) begin
            if (sel_ctrl) ctrl <= wdata[`WORPC_CTRL_W-1:0];
            if (sel_sleep) sleep_ticks <= wdata[TW-1:0];
            if (sel_win) rx_window <= wdata[TW-1:0];
            if (sel_calint) cal_interval <= wdata[TW-1:0];
            if (sel_dwell) dwell <= wdata[TW-1:0];
            if (sel_ien) irq_en <= wdata[`WORPC_IRQ_W-1:0];
        end
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= rd ? rd_mux : 32'h00000000;
        end
    end

    // ======================================================
    // rc clock sampled as a level; its rising edge is the tick
    assign rc_tick = rc_clk_in & !rc_q;

    // free-running sleep time base and edge history
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rc_q <= 1'b0;
            wake_time <= '0;
        end else begin
            rc_q <= rc_clk_in;
            if (rc_tick) wake_time <= wake_time + TW'(1);
        end
    end

    // ======================================================
    // signal validity source chosen by configuration
    assign sig_valid = ctrl[`WORPC_CTRL_PRE] ? radio.preamble_det :
        radio.rssi_above;
    assign enter_sleep = (next_state == WORPC_SLEEP) &&
        (state != WORPC_SLEEP);
    assign enter_listen = (next_state == WORPC_LISTEN) &&
        (state != WORPC_LISTEN);
    assign cal_fin = (state == WORPC_CAL) && cal_arm && rc_tick;

    // sleep interval counts rc ticks, not reference cycles
    worpc_countdown #(.W(TW)) u_sleep (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(enter_sleep),
        .load(sleep_ticks),
        .en(rc_tick && state == WORPC_SLEEP),
        .done(sleep_done),
        .busy(),
        .count(sleep_cnt)
    );

    // listen window in reference cycles sets the duty cycle
    worpc_countdown #(.W(TW)) u_window (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(enter_listen),
        .load(rx_window),
        .en(state == WORPC_LISTEN),
        .done(win_done),
        .busy(),
        .count(win_cnt)
    );

    // wake-up counter between calibrations
    worpc_countdown #(.W(TW)) u_calint (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(!calint_busy),
        .load(cal_interval),
        .en(sleep_done),
        .done(calint_done),
        .busy(calint_busy),
        .count()
    );

    // ======================================================
    // polling sequencer
    always_comb begin
        next_state = state;
        case (state)
            WORPC_IDLE: begin
                if (ctrl[`WORPC_CTRL_POLL]) next_state = WORPC_SLEEP;
            end
            WORPC_SLEEP: begin
                if (!ctrl[`WORPC_CTRL_POLL]) next_state = WORPC_IDLE;
                else if (sleep_done)
                    next_state = (ctrl[`WORPC_CTRL_AUTOCAL] &&
                        (cal_due || calint_done)) ? WORPC_CAL :
                        WORPC_LISTEN;
            end
            WORPC_CAL: begin
                if (cal_fin) next_state = WORPC_LISTEN;
            end
            WORPC_LISTEN: begin
                if (sig_valid) next_state = WORPC_PACKET;
                else if (win_done || !ctrl[`WORPC_CTRL_POLL])
                    next_state = WORPC_SLEEP;
            end
            WORPC_PACKET: begin
                if (radio.pkt_done)
                    next_state = radio.ack_req ? WORPC_ACK : WORPC_SLEEP;
            end
            WORPC_ACK: begin
                if (radio.ack_done) next_state = WORPC_SLEEP;
            end
            default: next_state = WORPC_IDLE;
        endcase
    end

    // state register; sleep and listen alternate while poll is set
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= WORPC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================
    // one rc period measured in reference cycles; a slow rc
    // shows a large count and is trimmed faster
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cal_arm <= 1'b0;
            cal_cnt <= 16'h0000;
            cal_due <= 1'b0;
            rc_trim <= `WORPC_RST_TRIM;
        end else begin
            if (calint_done) cal_due <= 1'b1;
            else if (state == WORPC_CAL) cal_due <= 1'b0;
            if (state != WORPC_CAL) begin
                cal_arm <= 1'b0;
            end else if (rc_tick && !cal_arm) begin
                cal_arm <= 1'b1;
                cal_cnt <= 16'h0000;
            end else if (cal_arm && cal_cnt != 16'hFFFF) begin
                cal_cnt <= cal_cnt + 16'h0001;
            end
            if (cal_fin) begin
                if (cal_cnt > CAL_NOM && rc_trim != 8'hFF)
                    rc_trim <= rc_trim + 8'h01;
                else if (cal_cnt < CAL_NOM && rc_trim != 8'h00)
                    rc_trim <= rc_trim - 8'h01;
            end
        end
    end

    // ======================================================
    // stamp and reference enable; the reference must run for
    // calibration and radio activity but never while asleep
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            timestamp <= '0;
            ext_ref_en <= 1'b0;
        end else begin
            if (state == WORPC_LISTEN && sig_valid)
                timestamp <= wake_time;
            ext_ref_en <= ctrl[`WORPC_CTRL_EXTREF] &&
                next_state != WORPC_SLEEP &&
                next_state != WORPC_IDLE;
        end
    end

    assign rx_on = (state == WORPC_LISTEN) || (state == WORPC_PACKET);
    assign ack_tx_on = (state == WORPC_ACK);

    // ======================================================
    // antenna search only while listening; frozen otherwise
    worpc_antsel #(.W(TW)) u_ant (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .search(ctrl[`WORPC_CTRL_DIV] && state == WORPC_LISTEN &&
            !sig_valid),
        .diff_mode(ctrl[`WORPC_CTRL_DIFF]),
        .dwell(dwell),
        .ant_sel(ant_sel),
        .ant_sel_n(ant_sel_n)
    );

    // ======================================================
    // sticky events; a set in the clearing cycle survives.
    // packet flag lets the host stay down until data waits
    assign irq_ev[`WORPC_IRQ_PKT] = (state == WORPC_PACKET) &&
        radio.pkt_done;
    assign irq_ev[`WORPC_IRQ_TMO] = (state == WORPC_LISTEN) &&
        !sig_valid && win_done;
    assign irq_ev[`WORPC_IRQ_CAL] = cal_fin;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~((wr && sel_iclr) ?
                wdata[`WORPC_IRQ_W-1:0] : '0)) | irq_ev;
        end
    end

    assign irq = |(irq_stat & irq_en);

    // ======================================================
    // checks
    property p_wake;
        @(posedge ref_clk) disable iff (!resetn)
        state == WORPC_SLEEP && sleep_done && ctrl[`WORPC_CTRL_POLL]
        |=> state == WORPC_LISTEN || state == WORPC_CAL;
    endproperty
    a_wake: assert property (p_wake)
        else $error("timer expiry did not wake receiver");

    property p_timeout;
        @(posedge ref_clk) disable iff (!resetn)
        state == WORPC_LISTEN && win_done && !sig_valid
        |=> state == WORPC_SLEEP &&
            (sleep_cnt == $past(sleep_ticks) || $past(sleep_ticks) == '0);
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("window expiry did not reload sleep");

    property p_window;
        @(posedge ref_clk) disable iff (!resetn)
        enter_listen && rx_window != '0 |=> win_cnt == $past(rx_window);
    endproperty
    a_window: assert property (p_window)
        else $error("listen window not loaded");

    property p_stamp;
        @(posedge ref_clk) disable iff (!resetn)
        state == WORPC_LISTEN && sig_valid
        |=> timestamp == $past(wake_time) && state == WORPC_PACKET;
    endproperty
    a_stamp: assert property (p_stamp)
        else $error("message not stamped");

    property p_rc_only;
        @(posedge ref_clk) disable iff (!resetn)
        state == WORPC_SLEEP && !rc_tick && !enter_sleep
        |=> $stable(sleep_cnt);
    endproperty
    a_rc_only: assert property (p_rc_only)
        else $error("sleep timer moved without rc tick");

    property p_cal;
        @(posedge ref_clk) disable iff (!resetn)
        state == WORPC_SLEEP && sleep_done && cal_due &&
        ctrl[`WORPC_CTRL_AUTOCAL] && ctrl[`WORPC_CTRL_POLL]
        |=> state == WORPC_CAL;
    endproperty
    a_cal: assert property (p_cal)
        else $error("due calibration skipped");

    property p_ref_off;
        @(posedge ref_clk) disable iff (!resetn)
        state == WORPC_SLEEP ##1 state == WORPC_SLEEP |-> !ext_ref_en;
    endproperty
    a_ref_off: assert property (p_ref_off)
        else $error("reference left on in sleep");

    property p_hold_rx;
        @(posedge ref_clk) disable iff (!resetn)
        state == WORPC_PACKET && !radio.pkt_done |=> state == WORPC_PACKET;
    endproperty
    a_hold_rx: assert property (p_hold_rx)
        else $error("receive left before packet end");

    property p_ack_hold;
        @(posedge ref_clk) disable iff (!resetn)
        state == WORPC_ACK ##1 state == WORPC_ACK |-> $stable(ant_sel);
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("antenna moved during acknowledge");

    c_cal: cover property (@(posedge ref_clk) disable iff (!resetn)
        cal_fin);
    c_ack: cover property (@(posedge ref_clk) disable iff (!resetn)
        state == WORPC_ACK && radio.ack_done);
    c_timeout: cover property (@(posedge ref_clk) disable iff (!resetn)
        irq_ev[`WORPC_IRQ_TMO]);
endmodule

//--- testbench/worpc_far_side.sv
// ==========================================================
// far side: rc oscillator and external antenna switch
module worpc_far_side (
    // rc oscillator
    output logic rc_clk,
    // antenna switch pins
    input wire logic ant_sel,
    input wire logic ant_sel_n,
    input wire logic diff_mode,
    // observations
    output logic [15:0] flips,
    output logic pair_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    // rc scaled to 10 ref cycles, keeps runs short
    initial rc_clk = 1'b0;
    always #20 rc_clk = ~rc_clk;
    // count every throw of the switch
    initial flips = 16'h0000;
    always @(ant_sel) flips = flips + 16'h0001;
    // pair must be complementary only in diff mode
    assign pair_bad = diff_mode ? (ant_sel_n !== ~ant_sel)
                                : (ant_sel_n !== 1'b0);
endmodule

//--- testbench/tb_worpc_poll_ctrl.sv
// ==========================================================
// bench for the polling controller
module tb_worpc_poll_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import worpc_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    worpc_radio_in_t radio = '0;
    logic rc_clk, rx_on, ack_tx_on, ext_ref_en, ant_sel, ant_sel_n, irq;
    logic pair_bad;
    logic [7:0] rc_trim;
    logic [15:0] flips, f0;
    int mismatches = 0, num_checks = 0, cycles = 0;
    logic [15:0] rc_count = 16'h0000, stamp_exp;
    // rc rises since reset, the bench's own sleep time base
    always @(posedge rc_clk) if (resetn) rc_count <= rc_count + 16'h0001;
    always #2 ref_clk = ~ref_clk;
    worpc_poll_ctrl #(.TW(16)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rc_clk_in(rc_clk), .rc_trim(rc_trim), .radio(radio),
        .rx_on(rx_on), .ack_tx_on(ack_tx_on), .ext_ref_en(ext_ref_en),
        .ant_sel(ant_sel), .ant_sel_n(ant_sel_n), .irq(irq));
    worpc_far_side far_u (.rc_clk(rc_clk), .ant_sel(ant_sel),
        .ant_sel_n(ant_sel_n), .diff_mode(1'b1), .flips(flips),
        .pair_bad(pair_bad));
    // ======================================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
        check(v & m, e);
    endtask
    task automatic wait_rx(input logic s);
        int n;
        n = 0;
        while (rx_on !== s && n < 3000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        check({31'h0, rx_on}, {31'h0, s});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // ======================================================
    // scenarios
    task automatic t_reset;
        rd_chk(8'h00, 32'hFFFFFFFF, 32'h0);
        rd_chk(8'h04, 32'hFFFFFFFF, 32'h10);
        rd_chk(8'h08, 32'hFFFFFFFF, 32'h100);
        rd_chk(8'h0C, 32'hFFFFFFFF, 32'h8);
        rd_chk(8'h10, 32'hFFFFFFFF, 32'h40);
        rd_chk(8'h18, 32'hFFFFFFFF, 32'h8000);
        rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
        rd_chk(8'h3C, 32'hFFFFFFFF, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_search;
        bus_wr(8'h04, 32'h2);
        bus_wr(8'h08, 32'h40);
        bus_wr(8'h10, 32'h4);
        bus_wr(8'h24, 32'h3);
        bus_wr(8'h00, 32'h7);
        wait_rx(1'b1);
        f0 = flips;
        wait_rx(1'b0);
        check({31'h0, (flips - f0) > 16'd8}, 32'h1);
        check({31'h0, pair_bad}, 32'h0);
        rd_chk(8'h1C, 32'h2, 32'h2);
        check({31'h0, irq}, 32'h1);
        bus_wr(8'h24, 32'h1);
        bus_wr(8'h20, 32'h2);
        idle(1);
        check({31'h0, irq}, 32'h0);
        $display("test search done");
    endtask
    task automatic t_packet;
        bus_wr(8'h00, 32'h1B);
        // start at a fresh window so it cannot run out mid-test
        wait_rx(1'b0);
        wait_rx(1'b1);
        bus_wr(8'h20, 32'h7);
        radio.rssi_above <= 1'b1;
        rd_chk(8'h18, 32'h7, 32'h3);
        radio.preamble_det <= 1'b1;
        // stamp taken at the next edge; no rc rise falls in between
        stamp_exp = rc_count;
        idle(3);
        rd_chk(8'h18, 32'h7, 32'h4);
        radio <= '0;
        idle(100);
        check({31'h0, rx_on}, 32'h1);
        check({31'h0, ext_ref_en}, 32'h1);
        radio.pkt_done <= 1'b1;
        radio.ack_req <= 1'b1;
        @(posedge ref_clk);
        radio <= '0;
        idle(2);
        f0 = flips;
        check({31'h0, ack_tx_on}, 32'h1);
        idle(20);
        check({16'h0, flips}, {16'h0, f0});
        radio.ack_done <= 1'b1;
        @(posedge ref_clk);
        radio <= '0;
        idle(2);
        check({30'h0, ack_tx_on, rx_on}, 32'h0);
        check({31'h0, ext_ref_en}, 32'h0);
        // host wakes on the flag, then reads
        check({31'h0, irq}, 32'h1);
        rd_chk(8'h1C, 32'h3, 32'h1);
        rd_chk(8'h14, 32'hFFFFFFFF, {16'h0000, stamp_exp});
        check({31'h0, v != 32'h0}, 32'h1);
        $display("test packet done");
    endtask
    // bench rc runs far above nominal, so one run must trim down
    task automatic t_cal;
        int n;
        n = 0;
        bus_wr(8'h0C, 32'h1);
        bus_wr(8'h20, 32'h7);
        bus_wr(8'h24, 32'h4);
        bus_wr(8'h00, 32'h21);
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        check({31'h0, irq}, 32'h1);
        rd_chk(8'h1C, 32'h4, 32'h4);
        rd_chk(8'h18, 32'hFF00, 32'h7F00);
        $display("test cal done");
    endtask
    // ======================================================
    // closing and hang guard
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_search();
        t_packet();
        t_cal();
        report_and_stop();
    end
endmodule
